// ==== rtl/debug_cmd_pkg.sv ====
package debug_cmd_pkg;

    // Response words and status
    localparam logic [15:0] RESP_DONE = 16'hffff;
    localparam logic [15:0] RESP_BUS_ERROR = 16'h0001;
    localparam logic [15:0] RESP_ILLEGAL = 16'hffff;
    localparam logic [15:0] RESP_NOT_READY = 16'h0000;

    // Whole-word commands
    localparam logic [15:0] CMD_NULL = 16'h0000;
    localparam logic [15:0] CMD_RESUME = 16'h0c00;
    localparam logic [15:0] CMD_CREG_READ = 16'h2980;
    localparam logic [15:0] CMD_CREG_WRITE = 16'h2880;

    // Upper opcode byte of sized memory commands
    localparam logic [7:0] OPC_FILL = 8'h1c;
    localparam logic [7:0] OPC_DUMP = 8'h1d;
    localparam logic [7:0] OPC_MEM_WRITE = 8'h18;
    localparam logic [7:0] OPC_MEM_READ = 8'h19;
    localparam int SIZE_LSB = 6;

    // Operand sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // Control register selection codes
    localparam logic [11:0] SEL_CACHE_CONTROL = 12'h002;
    localparam logic [11:0] SEL_ACCESS_CONTROL_ZERO = 12'h004;
    localparam logic [11:0] SEL_ACCESS_CONTROL_ONE = 12'h005;
    localparam logic [11:0] SEL_INACTIVE_STACK_POINTER = 12'h800;
    localparam logic [11:0] SEL_VECTOR_BASE = 12'h801;
    localparam logic [11:0] SEL_MULTIPLY_ACCUMULATE_STATUS = 12'h804;
    localparam logic [11:0] SEL_MULTIPLY_ACCUMULATE_MASK = 12'h805;
    localparam logic [11:0] SEL_ACCUMULATOR_ZERO = 12'h806;
    localparam logic [11:0] SEL_EXTENSION_BYTES_LOW_PAIR = 12'h807;
    localparam logic [11:0] SEL_EXTENSION_BYTES_HIGH_PAIR = 12'h808;
    localparam logic [11:0] SEL_ACCUMULATOR_ONE = 12'h809;
    localparam logic [11:0] SEL_ACCUMULATOR_TWO = 12'h80a;
    localparam logic [11:0] SEL_ACCUMULATOR_THREE = 12'h80b;
    localparam logic [11:0] SEL_PROCESSOR_STATUS_REGISTER = 12'h80e;
    localparam logic [11:0] SEL_PROGRAM_COUNTER = 12'h80f;
    localparam logic [11:0] SEL_FLASH_BASE_ADDRESS = 12'hc04;
    localparam logic [11:0] SEL_RAM_BASE_ADDRESS = 12'hc05;

    // Link frame, counted in link clock edges
    localparam logic [4:0] LINK_LOAD = 5'h02;
    localparam logic [4:0] LINK_LAST = 5'h13;

    // Pointer reset value and operand word counts
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [1:0] OPND_LONG_WORDS = 2'h2;
    localparam logic [1:0] OPND_WRITE_WORDS = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPERAND = 3'b010,
        ST_BUS = 3'b100
    } engine_state_t;

    typedef enum logic [1:0] {
        PREV_OTHER = 2'h0,
        PREV_WRITE = 2'h1,
        PREV_READ = 2'h2,
        PREV_NULL = 2'h3
    } prev_t;

    typedef enum logic [1:0] {
        OP_FILL = 2'h0,
        OP_DUMP = 2'h1,
        OP_CREG_READ = 2'h2,
        OP_CREG_WRITE = 2'h3
    } op_t;

    typedef struct packed {
        logic status;
        logic [15:0] data;
    } resp_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic ctrl;
        logic acc_touch;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } mem_ans_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
    } ext_done_t;

endpackage

// ==== rtl/debug_serial_command_engine.sv ====
`timescale 1ns/1ns

// Summary of operation
// RL1 - Block read returns word or longword, byte in low byte; bus error 0x0001, S set.
// RL2 - After each fill write without a bus error, saved address advances by 1, 2 or 4.
// RL3 - Fill accepted only after memory write, fill or null command, else illegal.
// RL4 - Null command between fills leaves the fill address untouched.
// RL5 - Operand size is decoded afresh on every fill command.
// RL6 - Host sends byte fill data in low byte, longwords as two words.
// RL7 - Fill completion answers 0xFFFF, S clear; bus error answers 0x0001, S set.
// RL8 - Resume flushes and refills the pipeline from current counter and privilege.
// RL9 - Registers changed while halted take effect when prefetch resumes.
// RL10 - Resume while the core runs is ignored.
// RL11 - Resume answers 0xFFFF in the following shift.
// RL12 - Null command does nothing and answers 0xFFFF with S clear.
// RL13 - Control register access is 32 bits via a special bus cycle.
// RL14 - Control register picked by a 12-bit selection code.
// RL15 - Codes for cache, access, stack, vector base, status and counter registers.
// RL16 - Codes for multiply-accumulate status, mask, accumulators and extension bytes.
// RL17 - Flash base 0xC04, RAM base 0xC05.
// RL18 - Control read returns high word first; unimplemented bits undefined.
// RL19 - Host maps active and inactive stack pointers using supervisor bit.
// RL20 - Host disables rounding before accumulator access.
// RL21 - Accumulator write also changes its extension; host writes extensions after.
// RL22 - Control write takes select then data longword; 0xFFFF or 0x0001 with S.
// RL23 - Status is 0 when normal, 1 for illegal, not-ready and bus error.
// RL24 - Unassigned command formats do nothing and answer illegal.
module debug_serial_command_engine
    import debug_cmd_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Serial link
    input wire logic link_clk,
    input wire logic link_din,
    output logic link_dout,
    // Processor core
    input wire logic cpu_halted,
    output logic resume_pulse,
    // Outer command block, reports single memory reads and writes
    input wire ext_done_t ext_done,
    // Memory and control register bus
    output mem_req_t bus_req,
    input wire mem_ans_t bus_ans
);

    function automatic logic [31:0] size_bytes(input logic [1:0] size);
        case (size)
            SIZE_BYTE: size_bytes = 32'h0000_0001;
            SIZE_WORD: size_bytes = 32'h0000_0002;
            default: size_bytes = 32'h0000_0004;
        endcase
    endfunction

    function automatic logic creg_known(input logic [11:0] sel);
        case (sel)
            SEL_CACHE_CONTROL, SEL_ACCESS_CONTROL_ZERO, SEL_ACCESS_CONTROL_ONE,
            SEL_INACTIVE_STACK_POINTER, SEL_VECTOR_BASE,
            SEL_PROCESSOR_STATUS_REGISTER, SEL_PROGRAM_COUNTER: creg_known = 1'b1; // RL15
            SEL_MULTIPLY_ACCUMULATE_STATUS, SEL_MULTIPLY_ACCUMULATE_MASK,
            SEL_ACCUMULATOR_ZERO, SEL_EXTENSION_BYTES_LOW_PAIR,
            SEL_EXTENSION_BYTES_HIGH_PAIR, SEL_ACCUMULATOR_ONE,
            SEL_ACCUMULATOR_TWO, SEL_ACCUMULATOR_THREE: creg_known = 1'b1; // RL16
            SEL_FLASH_BASE_ADDRESS, SEL_RAM_BASE_ADDRESS: creg_known = 1'b1; // RL17
            default: creg_known = 1'b0;
        endcase
    endfunction

    function automatic logic is_accumulator(input logic [11:0] sel);
        is_accumulator = (sel == SEL_ACCUMULATOR_ZERO) || (sel == SEL_ACCUMULATOR_ONE) ||
            (sel == SEL_ACCUMULATOR_TWO) || (sel == SEL_ACCUMULATOR_THREE);
    endfunction

    // Words owned by the outer command block: single memory, address/data and
    // debug module register commands
    function automatic logic is_foreign(input logic [15:0] w);
        is_foreign = (w[15:8] == OPC_MEM_READ) || (w[15:8] == OPC_MEM_WRITE) ||
            ((w[15:12] == 4'h2) && (w[11:8] != 4'h8) && (w[11:8] != 4'h9));
    endfunction

    // Link clock domain
    logic [4:0] link_cnt;
    logic [16:0] rx_shift;
    logic [16:0] tx_shift;
    logic [15:0] rx_word;
    logic rx_tgl;
    logic resp_l1;
    logic resp_l2;
    logic resp_seen;

    // System domain response handed to the link
    resp_t resp_hold;
    logic resp_tgl;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_l1 <= 1'b0;
            resp_l2 <= 1'b0;
        end else begin
            resp_l1 <= resp_tgl;
            resp_l2 <= resp_l1;
        end
    end

    // Two leading edges of each frame let the response toggle settle, since
    // the link clock may be stopped between frames
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_cnt <= 5'h00;
            rx_shift <= 17'h0_0000;
            tx_shift <= 17'h0_0000;
            rx_word <= 16'h0000;
            rx_tgl <= 1'b0;
            resp_seen <= 1'b0;
            link_dout <= 1'b0;
        end else begin
            link_cnt <= (link_cnt == LINK_LAST) ? 5'h00 : link_cnt + 5'h01;
            if (link_cnt == LINK_LOAD) begin
                if (resp_l2 != resp_seen) begin
                    link_dout <= resp_hold.status;
                    tx_shift <= {resp_hold[15:0], 1'b0};
                    resp_seen <= resp_l2;
                end else begin
                    link_dout <= 1'b1; // RL23
                    tx_shift <= {RESP_NOT_READY, 1'b0};
                end
            end else if (link_cnt > LINK_LOAD) begin
                link_dout <= tx_shift[16];
                tx_shift <= {tx_shift[15:0], 1'b0};
            end
            if (link_cnt > LINK_LOAD) begin
                rx_shift <= {rx_shift[15:0], link_din};
            end
            if (link_cnt == LINK_LAST) begin
                rx_word <= {rx_shift[14:0], link_din};
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    // System clock domain
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic word_new;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_s3 <= 1'b0;
        end else begin
            rx_s1 <= rx_tgl;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // rx_word is stable for a whole frame after the toggle
    assign word_new = rx_s2 ^ rx_s3;

    engine_state_t state;
    op_t op;
    prev_t prev;
    logic [1:0] op_size;
    logic [1:0] opnd_left;
    logic [47:0] opnd;
    logic [31:0] ptr;
    resp_t lo_word;
    logic lo_pend;

    // Command decode of a word arriving in the idle state
    logic dec_imm;
    resp_t dec_resp;
    engine_state_t dec_state;
    op_t dec_op;
    logic [1:0] dec_words;
    prev_t dec_prev;
    logic dec_go;
    logic [1:0] w_size;
    logic size_ok;

    always_comb begin
        w_size = rx_word[SIZE_LSB +: 2];
        size_ok = (w_size != 2'h3) && (rx_word[5:0] == 6'h00);
        dec_imm = 1'b0;
        dec_resp = '{status: 1'b0, data: RESP_DONE};
        dec_state = ST_IDLE;
        dec_op = op;
        dec_words = 2'h0;
        dec_prev = PREV_OTHER;
        dec_go = 1'b0;
        if (is_foreign(rx_word)) begin
            dec_prev = PREV_OTHER;
        end else if (rx_word == CMD_NULL) begin
            dec_imm = 1'b1; // RL12
            dec_prev = PREV_NULL;
        end else if (rx_word == CMD_RESUME) begin
            dec_imm = 1'b1; // RL11
            dec_go = cpu_halted; // RL10
        end else if ((rx_word[15:8] == OPC_FILL) && size_ok &&
                     ((prev == PREV_WRITE) || (prev == PREV_NULL))) begin // RL3
            dec_state = ST_OPERAND;
            dec_op = OP_FILL;
            dec_words = (w_size == SIZE_LONG) ? OPND_LONG_WORDS : 2'h1; // RL6
            dec_prev = PREV_WRITE;
        end else if ((rx_word[15:8] == OPC_DUMP) && size_ok &&
                     ((prev == PREV_READ) || (prev == PREV_NULL))) begin
            dec_state = ST_BUS;
            dec_op = OP_DUMP;
            dec_prev = PREV_READ;
        end else if (rx_word == CMD_CREG_READ) begin
            dec_state = ST_OPERAND;
            dec_op = OP_CREG_READ;
            dec_words = OPND_LONG_WORDS; // RL13
        end else if (rx_word == CMD_CREG_WRITE) begin
            dec_state = ST_OPERAND;
            dec_op = OP_CREG_WRITE;
            dec_words = OPND_WRITE_WORDS; // RL22
        end else begin
            dec_imm = 1'b1; // RL24
            dec_resp = '{status: 1'b1, data: RESP_ILLEGAL}; // RL23
        end
    end

    // Result of a finished bus cycle
    resp_t bus_resp;
    resp_t bus_lo;
    logic bus_lo_pend;

    always_comb begin
        bus_resp = '{status: 1'b0, data: RESP_DONE}; // RL7
        bus_lo = '{status: 1'b0, data: bus_ans.rdata[15:0]};
        bus_lo_pend = 1'b0;
        if (bus_ans.err) begin
            bus_resp = '{status: 1'b1, data: RESP_BUS_ERROR}; // RL1 RL7 RL22
        end else if ((op == OP_DUMP) || (op == OP_CREG_READ)) begin
            if ((op == OP_CREG_READ) || (op_size == SIZE_LONG)) begin
                bus_resp.data = bus_ans.rdata[31:16]; // RL18
                bus_lo_pend = 1'b1;
            end else if (op_size == SIZE_WORD) begin
                bus_resp.data = bus_ans.rdata[15:0];
            end else begin
                bus_resp.data = {8'h00, bus_ans.rdata[7:0]}; // RL1
            end
        end
    end

    logic [31:0] last_word;
    assign last_word = {opnd[15:0], rx_word};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            op <= OP_FILL;
            prev <= PREV_OTHER;
            op_size <= SIZE_BYTE;
            opnd_left <= 2'h0;
            opnd <= 48'h0;
            ptr <= PTR_RESET;
            lo_word <= '0;
            lo_pend <= 1'b0;
            resp_hold <= '0;
            resp_tgl <= 1'b0;
            resume_pulse <= 1'b0;
            bus_req <= '0;
        end else begin
            resume_pulse <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (word_new) begin
                        // A pending low result word rides on the next opcode's frame
                        if (lo_pend) begin
                            resp_hold <= lo_word;
                            resp_tgl <= ~resp_tgl;
                            lo_word <= dec_resp;
                            lo_pend <= dec_imm;
                        end else if (dec_imm) begin
                            resp_hold <= dec_resp;
                            resp_tgl <= ~resp_tgl;
                        end
                        resume_pulse <= dec_go; // RL8 RL9
                        state <= dec_state;
                        op <= dec_op;
                        opnd_left <= dec_words;
                        // Null is recorded so that a fill may follow padding
                        prev <= dec_prev; // RL3
                        if (dec_state != ST_IDLE) begin
                            op_size <= w_size; // RL5
                        end
                        if (dec_op == OP_DUMP && dec_state == ST_BUS) begin
                            bus_req <= '{valid: 1'b1, write: 1'b0, ctrl: 1'b0, acc_touch: 1'b0,
                                         size: w_size, addr: ptr, wdata: 32'h0};
                        end
                    end
                end
                ST_OPERAND: begin
                    if (word_new) begin
                        opnd <= {opnd[31:0], rx_word};
                        opnd_left <= opnd_left - 2'h1;
                        if (opnd_left == 2'h1) begin
                            state <= ST_BUS;
                            case (op)
                                OP_FILL: begin
                                    bus_req <= '{valid: 1'b1, write: 1'b1, ctrl: 1'b0,
                                                 acc_touch: 1'b0, size: op_size, addr: ptr,
                                                 wdata: (op_size == SIZE_LONG) ? last_word
                                                     : {16'h0000, rx_word}};
                                end
                                OP_CREG_READ: begin
                                    bus_req <= '{valid: creg_known(rx_word[11:0]), write: 1'b0,
                                                 ctrl: 1'b1, acc_touch: 1'b0, size: SIZE_LONG,
                                                 addr: last_word, wdata: 32'h0}; // RL13 RL14
                                end
                                default: begin
                                    // Select code sits in the second operand word
                                    bus_req <= '{valid: creg_known(opnd[27:16]), write: 1'b1,
                                                 ctrl: 1'b1,
                                                 acc_touch: is_accumulator(opnd[27:16]),
                                                 size: SIZE_LONG, addr: opnd[47:16],
                                                 wdata: last_word}; // RL21 RL22
                                end
                            endcase
                        end
                    end
                end
                ST_BUS: begin
                    // Unknown selection codes end as a bus error with no cycle
                    if (!bus_req.valid) begin
                        state <= ST_IDLE;
                        resp_hold <= '{status: 1'b1, data: RESP_BUS_ERROR};
                        resp_tgl <= ~resp_tgl;
                    end else if (bus_ans.ack) begin
                        state <= ST_IDLE;
                        bus_req.valid <= 1'b0;
                        resp_hold <= bus_resp;
                        resp_tgl <= ~resp_tgl;
                        lo_word <= bus_lo;
                        lo_pend <= bus_lo_pend;
                        if (!bus_ans.err && ((op == OP_FILL) || (op == OP_DUMP))) begin
                            ptr <= ptr + size_bytes(op_size); // RL2 RL4
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Single read or write done by the outer block opens a block
            if (ext_done.valid) begin
                ptr <= ext_done.addr + size_bytes(ext_done.size); // RL2
                prev <= ext_done.write ? PREV_WRITE : PREV_READ; // RL3
            end
        end
    end

endmodule

// ==== sim/host_link_model.sv ====
`timescale 1ns/1ns
module host_link_model (
    // Serial link
    output logic link_clk,
    output logic link_din,
    input wire logic link_dout
);
    initial begin
        link_clk = 1'b0;
        link_din = 1'b0;
    end

    // Clock runs only inside a frame; gap leaves room for bus time
    task automatic frame(input logic [15:0] w, output logic [16:0] r);
        for (int e = 0; e < 20; e++) begin
            link_din <= (e < 4) ? ~link_din : w[19 - e];
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
            if (e >= 2 && e <= 18) begin
                r[18 - e] = link_dout;
            end
        end
        link_din <= ~link_din;
        #400;
    endtask
endmodule

// ==== sim/debug_cmd_monitor.sv ====
`timescale 1ns/1ns
module debug_cmd_monitor
    import debug_cmd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Core and bus
    input wire logic cpu_halted,
    input wire logic resume_pulse,
    input wire ext_done_t ext_done,
    input wire mem_req_t bus_req,
    input wire mem_ans_t bus_ans
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    logic [31:0] ptr;
    logic acc_sel;

    // Expected block pointer; error leaves it alone
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ptr <= 32'h0;
        end else if (ext_done.valid) begin
            ptr <= ext_done.addr + (32'h1 << ext_done.size);
        end else if (bus_req.valid && bus_ans.ack && !bus_ans.err && !bus_req.ctrl) begin
            ptr <= bus_req.addr + (32'h1 << bus_req.size);
        end
    end

    assign acc_sel = bus_req.addr[11:0] inside {12'h806, 12'h809, 12'h80a, 12'h80b};

    sequence s_waiting;
        bus_req.valid && !bus_ans.ack;
    endsequence
    sequence s_acked;
        bus_req.valid && bus_ans.ack;
    endsequence

    AST_REQ_HOLD: assert property (s_waiting |=> $stable(bus_req))
        else $error("bus request changed before ack");
    AST_REQ_DROP: assert property (s_acked |=> !bus_req.valid)
        else $error("bus request held after ack");
    AST_CTRL_LONG: assert property (bus_req.valid && bus_req.ctrl |->
        bus_req.size == SIZE_LONG)
        else $error("control cycle not longword");
    AST_CTRL_SEL: assert property (bus_req.valid && bus_req.ctrl |-> bus_req.addr[11:0] inside {
        12'h002, 12'h004, 12'h005, 12'h800, 12'h801, 12'h804, 12'h805, 12'h806, 12'h807,
        12'h808, 12'h809, 12'h80a, 12'h80b, 12'h80e, 12'h80f, 12'hc04, 12'hc05})
        else $error("control cycle with unknown select");
    AST_ACC_TOUCH: assert property (bus_req.valid && bus_req.ctrl && bus_req.write
        |-> bus_req.acc_touch == acc_sel)
        else $error("accumulator flag wrong");
    AST_BLOCK_ADDR: assert property (bus_req.valid && !bus_req.ctrl |-> bus_req.addr == ptr)
        else $error("block address not advanced by size");
    AST_PULSE_ONE: assert property (resume_pulse |=> !resume_pulse)
        else $error("resume pulse too long");
    AST_RESUME_HALT: assert property (resume_pulse |-> cpu_halted && $past(cpu_halted))
        else $error("resume while running");
endmodule

bind debug_serial_command_engine debug_cmd_monitor u_mon (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cpu_halted(cpu_halted),
    .resume_pulse(resume_pulse),
    .ext_done(ext_done),
    .bus_req(bus_req),
    .bus_ans(bus_ans)
);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import debug_cmd_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cpu_halted = 1'b0;
    ext_done_t ext_done = '0;
    mem_ans_t bus_ans = '0;
    logic link_clk;
    logic link_din;
    logic link_dout;
    logic resume_pulse;
    mem_req_t bus_req;
    mem_req_t seen;
    logic bus_err = 1'b0;
    logic [31:0] bus_rdata = 32'h1234_5678;
    logic [16:0] r;
    int bus_wait = 0;
    int pulse_cnt = 0;
    int error_cnt = 0;
    int tests_run = 0;
    // Accumulators before extensions, status first; stack pointers go by select code only
    logic [11:0] sels [17] = '{12'h002, 12'h004, 12'h005, 12'h800, 12'h801, 12'h804,
        12'h805, 12'h806, 12'h809, 12'h80a, 12'h80b, 12'h807, 12'h808, 12'h80e,
        12'h80f, 12'hc04, 12'hc05};

    always #5 clk_sys = ~clk_sys;

    host_link_model host (.link_clk(link_clk), .link_din(link_din), .link_dout(link_dout));

    debug_serial_command_engine DUT (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .link_clk(link_clk),
        .link_din(link_din),
        .link_dout(link_dout),
        .cpu_halted(cpu_halted),
        .resume_pulse(resume_pulse),
        .ext_done(ext_done),
        .bus_req(bus_req),
        .bus_ans(bus_ans)
    );

    // Bus answers on the third cycle; data toggles in every cycle without an answer
    always @(posedge clk_sys) begin
        if (resume_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
        if (bus_req.valid === 1'b1 && !bus_ans.ack && bus_wait == 2) begin
            bus_ans <= {1'b1, bus_err, bus_rdata};
            seen <= bus_req;
            bus_wait <= 0;
        end else begin
            bus_ans.ack <= 1'b0;
            bus_ans.rdata <= ~bus_ans.rdata;
            if (bus_req.valid === 1'b1 && !bus_ans.ack) bus_wait <= bus_wait + 1;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Errors %0d in %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic xfer(input logic [15:0] w);
        host.frame(w, r);
    endtask

    task automatic mem_done(input logic wr, input logic [1:0] sz, input logic [31:0] a);
        @(posedge clk_sys) ext_done <= {1'b1, wr, sz, a};
        @(posedge clk_sys) ext_done <= '0;
    endtask

    task automatic test_start();
        xfer({OPC_FILL, 8'h00});
        xfer(CMD_NULL);
        check(r, {1'b1, RESP_ILLEGAL});
        xfer(CMD_NULL);
        check(r, {1'b0, RESP_DONE});
    endtask

    task automatic fill_one(input logic [1:0] sz, input logic [31:0] d, input logic [31:0] a);
        logic [31:0] m;
        m = (sz == SIZE_BYTE) ? 32'hff : (sz == SIZE_WORD) ? 32'hffff : 32'hffff_ffff;
        xfer({OPC_FILL, sz, 6'h0});
        if (sz == SIZE_LONG) xfer(d[31:16]);
        xfer(d[15:0]);
        xfer(CMD_NULL);
        check(r, bus_err ? {1'b1, RESP_BUS_ERROR} : {1'b0, RESP_DONE});
        check(seen.addr, a);
        check(seen.wdata & m, d);
        check({seen.write, seen.ctrl, seen.size}, {2'b10, sz});
    endtask

    task automatic test_fill();
        mem_done(1'b1, SIZE_BYTE, 32'h1000);
        fill_one(SIZE_BYTE, 32'hdd, 32'h1001);
        fill_one(SIZE_WORD, 32'h1234, 32'h1002);
        fill_one(SIZE_LONG, 32'hcafe_f00d, 32'h1004);
        bus_err = 1'b1;
        fill_one(SIZE_BYTE, 32'hee, 32'h1008);
        bus_err = 1'b0;
        fill_one(SIZE_BYTE, 32'h11, 32'h1008);
    endtask

    task automatic test_dump();
        mem_done(1'b0, SIZE_WORD, 32'h2000);
        xfer({OPC_DUMP, SIZE_WORD, 6'h0});
        xfer(CMD_NULL);
        check(r, {1'b0, bus_rdata[15:0]});
        check(seen.addr, 32'h2002);
        xfer(CMD_NULL);
    endtask

    task automatic test_resume();
        int n;
        n = pulse_cnt;
        @(posedge clk_sys) cpu_halted <= 1'b1;
        xfer(CMD_RESUME);
        xfer(CMD_NULL);
        check(r, {1'b0, RESP_DONE});
        check(pulse_cnt, n + 1);
        @(posedge clk_sys) cpu_halted <= 1'b0;
        xfer(CMD_RESUME);
        xfer(CMD_NULL);
        check(pulse_cnt, n + 1);
    endtask

    task automatic test_creg_read();
        xfer(CMD_CREG_READ);
        xfer(16'h0);
        xfer({4'h0, SEL_PROGRAM_COUNTER});
        xfer(CMD_NULL);
        check(r, {1'b0, bus_rdata[31:16]});
        xfer(CMD_NULL);
        check(r, {1'b0, bus_rdata[15:0]});
        check({seen.ctrl, seen.write, seen.addr[11:0]}, {2'b10, SEL_PROGRAM_COUNTER});
        xfer(CMD_NULL);
        xfer(CMD_NULL);
    endtask

    task automatic test_creg_write();
        logic [31:0] d;
        for (int i = 0; i < 17; i++) begin
            d = {20'ha5c3e, sels[i]};
            bus_err = (i == 16);
            xfer(CMD_CREG_WRITE);
            xfer(16'h0);
            xfer({4'h0, sels[i]});
            xfer(d[31:16]);
            xfer(d[15:0]);
            xfer(CMD_NULL);
            check(r, bus_err ? {1'b1, RESP_BUS_ERROR} : {1'b0, RESP_DONE});
            check({seen.ctrl, seen.write, seen.addr[11:0]}, {2'b11, sels[i]});
            check(seen.wdata, d);
        end
        bus_err = 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        test_start();
        test_fill();
        test_dump();
        test_resume();
        test_creg_read();
        test_creg_write();
        conclude();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
endmodule
